/* File: design/tmc_regs.vh */
// Register offsets, field positions and counts for the timer/counter block
`ifndef TMC_REGS_VH
`define TMC_REGS_VH
`define TMC_ADDR_TCS      8'h88
`define TMC_ADDR_TMC      8'h89
`define TMC_ADDR_T0LO     8'h8a
`define TMC_ADDR_T1LO     8'h8b
`define TMC_ADDR_T0HI     8'h8c
`define TMC_ADDR_T1HI     8'h8d
`define TMC_ADDR_T2CTL    8'hc8
`define TMC_ADDR_CRLO     8'hca
`define TMC_ADDR_CRHI     8'hcb
`define TMC_ADDR_T2LO     8'hcc
`define TMC_ADDR_T2HI     8'hcd
`define TMC_TCS_RESET     8'h00
`define TMC_TMC_RESET     8'h00
`define TMC_T2CTL_RESET   8'h00
`define TMC_CR_RESET      8'h00
`define TMC_CNT_RESET     8'h00
`define TMC_BIT_OVF1      7
`define TMC_BIT_RUN1      6
`define TMC_BIT_OVF0      5
`define TMC_BIT_RUN0      4
`define TMC_BIT_XFLAG1    3
`define TMC_BIT_XTYPE1    2
`define TMC_BIT_XFLAG0    1
`define TMC_BIT_XTYPE0    0
`define TMC_FLD_GATE      3
`define TMC_FLD_CT        2
`define TMC_FLD_MODE_HI   1
`define TMC_FLD_MODE_LO   0
`define TMC_MODE_13BIT    2'b00
`define TMC_MODE_16BIT    2'b01
`define TMC_MODE_RELOAD   2'b10
`define TMC_MODE_SPLIT    2'b11
`define TMC_BIT_PRESC     7
`define TMC_RLD_HI        4
`define TMC_RLD_LO        3
`define TMC_SEL_HI        1
`define TMC_SEL_LO        0
`define TMC_RLD_OVF       2'b10
`define TMC_RLD_EDGE      2'b11
`define TMC_SEL_STOP      2'b00
`define TMC_SEL_CLK       2'b01
`define TMC_SEL_EDGE      2'b10
`define TMC_SEL_GATED     2'b11
`define TMC_DIV_CYCLES    4'd12
`define TMC_DIV_LAST      4'd11
`define TMC_DIV_ZERO      4'd0
`endif

/* File: design/tmc_timers.v */
// Timer zero, one and two with their special function registers
// Summary of operation
// - Timers zero and one tick every 12 cycles.
// - Counter mode advances on external input falling edge.
// - Edge detect takes two cycles; input stable one.
// - Mode 0 is 13-bit, top three bits of the low byte held.
// - Mode 1 is a full 16-bit counter.
// - Mode 2 is 8-bit counter with auto reload.
// - Mode 3 splits timer zero; timer one holds.
// - Overflows set flags at bits 7 and 5.
// - Run bits 6 and 4 gate counting.
// - Flags clear when service routine is entered; level flags hold while pin low.
// - Type bits pick edge or level; flags set.
// - Mode register holds gate, select, mode fields.
// - Mode field selects 13, 16, reload, split.
// - Timer two ticks every 12 or 24 cycles.
// - Event mode counts cycle after sampled fall.
// - Gated mode stops while external input low.
// - Reload mode 0 loads compare value on overflow.
// - Reload mode 1 loads on trigger falling edge.
// - Trigger is low frequency clock halved internally.
// - Timer zero bytes at 0x8a and 0x8c.
// - Prescale select bit 7 picks 12 or 24.
// - Reload field 0X off, 10 overflow, 11 edge.
// - Input select stop, clock, edge, gated clock.
`include "tmc_regs.vh"
module tmc_timers (
  input  wire       ref_clk,
  input  wire       srst,
  input  wire [7:0] sfr_addr,
  input  wire [7:0] sfr_wdata,
  input  wire       sfr_wr,
  input  wire       sfr_rd,
  output reg  [7:0] sfr_rdata,
  input  wire       timer_zero_count_input,
  input  wire       timer_one_count_input,
  input  wire       timer_two_external_input,
  input  wire       ext_irq_zero_n,
  input  wire       ext_irq_one_n,
  input  wire       low_frequency_clock,
  input  wire       ack_timer_zero,
  input  wire       ack_timer_one,
  input  wire       ack_ext_irq_zero,
  input  wire       ack_ext_irq_one,
  output wire       timer_zero_overflow_flag,
  output wire       timer_one_overflow_flag,
  output wire       ext_irq_zero_flag,
  output wire       ext_irq_one_flag
);

  reg  [7:0] tcs_reg;
  reg  [7:0] tmc_reg;
  reg  [7:0] t2ctl_reg;
  reg  [7:0] cr_lo_reg;
  reg  [7:0] cr_hi_reg;
  reg  [15:0] two_cnt_reg;
  reg  [7:0] lo_reg [0:1];
  reg  [7:0] hi_reg [0:1];
  reg  [3:0] div_reg;
  reg        half_reg;
  reg  [5:0] sync1_reg;
  reg  [5:0] sync2_reg;
  reg  [5:0] prev_reg;
  reg        lf_div_reg;
  reg        lf_div_prev_reg;
  reg        two_fall_reg;
  wire       tick12;
  wire       two_tick;
  wire [5:0] fall;
  wire [1:0] low_ovf;
  wire [1:0] high_ovf;
  wire [1:0] pin_high;
  wire       split_mode;
  wire [1:0] reload_sel;
  wire [1:0] input_sel;
  wire       two_step;
  wire       two_ovf;
  wire       trig_fall;

  // Sync order: count0, count1, ext0, ext1, timer-two input, low freq clock
  wire [5:0] raw_in = {low_frequency_clock, timer_two_external_input, ext_irq_one_n,
                       ext_irq_zero_n, timer_one_count_input, timer_zero_count_input};

  // Two flops per pin, then a third stage kept only for edge detection
  always @(posedge ref_clk) begin
    if (srst) begin
      sync1_reg <= 6'h3f;
      sync2_reg <= 6'h3f;
      prev_reg  <= 6'h3f;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // A high-to-low change seen across two samples, so fastest rate is half the clock
  assign fall = prev_reg & ~sync2_reg;
  assign pin_high = sync2_reg[3:2];

  // Shared divide-by-12 prescaler; the half bit gives the divide-by-24 tick
  always @(posedge ref_clk) begin
    if (srst) begin
      div_reg  <= `TMC_DIV_ZERO;
      half_reg <= 1'b0;
    end else if (div_reg == `TMC_DIV_LAST) begin
      div_reg  <= `TMC_DIV_ZERO;
      half_reg <= ~half_reg;
    end else begin
      div_reg <= div_reg + 4'd1;
    end
  end

  assign tick12 = (div_reg == `TMC_DIV_LAST);
  assign split_mode = (tmc_reg[1:0] == `TMC_MODE_SPLIT);

  // Timers zero and one share one structure; index 0 is timer zero
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_tmr
      wire [3:0] cfg  = tmc_reg[4*i+3:4*i];
      wire [1:0] mode = cfg[`TMC_FLD_MODE_HI:`TMC_FLD_MODE_LO];
      wire       run  = tcs_reg[`TMC_BIT_RUN0 + 2*i];
      // Gate bit also needs the interrupt pin high
      wire       go   = run & (~cfg[`TMC_FLD_GATE] | pin_high[i]);
      wire       src  = cfg[`TMC_FLD_CT] ? fall[i] : tick12;
      wire       en   = go & src;
      // Timer one holds in its own split code
      wire       hold = (i == 1) && (mode == `TMC_MODE_SPLIT);
      // In split mode the high byte of timer zero borrows the timer one run bit
      wire       hi_en = (i == 0) && split_mode && tcs_reg[`TMC_BIT_RUN1] && tick12;
      wire       wr_lo = sfr_wr && (sfr_addr == ((i == 0) ? `TMC_ADDR_T0LO : `TMC_ADDR_T1LO));
      wire       wr_hi = sfr_wr && (sfr_addr == ((i == 0) ? `TMC_ADDR_T0HI : `TMC_ADDR_T1HI));
      reg        ovf_c;
      reg        hovf_c;
      reg  [7:0] lo_next;
      reg  [7:0] hi_next;

      // Next count per mode; a software write to a byte overrides counting
      always @* begin
        lo_next = lo_reg[i];
        hi_next = hi_reg[i];
        ovf_c   = 1'b0;
        hovf_c  = 1'b0;
        if (en && !hold) begin
          case (mode)
            `TMC_MODE_13BIT: begin
              // Only five low bits join the high byte
              {hi_next, lo_next[4:0]} = {hi_reg[i], lo_reg[i][4:0]} + 13'd1;
              ovf_c = (hi_reg[i] == 8'hff) && (lo_reg[i][4:0] == 5'h1f);
            end
            `TMC_MODE_16BIT: begin
              {hi_next, lo_next} = {hi_reg[i], lo_reg[i]} + 16'd1;
              ovf_c = ({hi_reg[i], lo_reg[i]} == 16'hffff);
            end
            `TMC_MODE_RELOAD: begin
              ovf_c = (lo_reg[i] == 8'hff);
              lo_next = ovf_c ? hi_reg[i] : lo_reg[i] + 8'd1;
            end
            `TMC_MODE_SPLIT: begin
              lo_next = lo_reg[i] + 8'd1;
              ovf_c = (lo_reg[i] == 8'hff);
            end
            default: begin
              lo_next = lo_reg[i];
            end
          endcase
        end
        if (hi_en) begin
          hi_next = hi_reg[i] + 8'd1;
          hovf_c  = (hi_reg[i] == 8'hff);
        end
        if (wr_lo) lo_next = sfr_wdata;
        if (wr_hi) hi_next = sfr_wdata;
      end

      always @(posedge ref_clk) begin
        if (srst) begin
          lo_reg[i] <= `TMC_CNT_RESET;
          hi_reg[i] <= `TMC_CNT_RESET;
        end else begin
          lo_reg[i] <= lo_next;
          hi_reg[i] <= hi_next;
        end
      end

      assign low_ovf[i]  = ovf_c;
      assign high_ovf[i] = hovf_c;
    end
  endgenerate

  // Flag set terms; timer one loses its flag while timer zero is split
  wire set_ovf0 = low_ovf[0];
  wire set_ovf1 = (low_ovf[1] & ~split_mode) | high_ovf[0];
  // Edge type catches falling edges; level type follows the low pin
  wire set_ext0 = tcs_reg[`TMC_BIT_XTYPE0] ? fall[2] : ~sync2_reg[2];
  wire set_ext1 = tcs_reg[`TMC_BIT_XTYPE1] ? fall[3] : ~sync2_reg[3];
  wire wr_tcs  = sfr_wr && (sfr_addr == `TMC_ADDR_TCS);
  reg  [7:0] tcs_next;

  // Software write first, then service clears, then hardware sets win last
  always @* begin
    tcs_next = wr_tcs ? sfr_wdata : tcs_reg;
    if (ack_timer_zero)   tcs_next[`TMC_BIT_OVF0] = 1'b0;
    if (ack_timer_one)    tcs_next[`TMC_BIT_OVF1] = 1'b0;
    if (ack_ext_irq_zero) tcs_next[`TMC_BIT_XFLAG0] = 1'b0;
    if (ack_ext_irq_one)  tcs_next[`TMC_BIT_XFLAG1] = 1'b0;
    if (set_ovf0) tcs_next[`TMC_BIT_OVF0] = 1'b1;
    if (set_ovf1) tcs_next[`TMC_BIT_OVF1] = 1'b1;
    if (set_ext0) tcs_next[`TMC_BIT_XFLAG0] = 1'b1;
    if (set_ext1) tcs_next[`TMC_BIT_XFLAG1] = 1'b1;
  end

  // Control registers written by the core
  always @(posedge ref_clk) begin
    if (srst) begin
      tcs_reg   <= `TMC_TCS_RESET;
      tmc_reg   <= `TMC_TMC_RESET;
      t2ctl_reg <= `TMC_T2CTL_RESET;
      cr_lo_reg <= `TMC_CR_RESET;
      cr_hi_reg <= `TMC_CR_RESET;
    end else begin
      tcs_reg <= tcs_next;
      if (sfr_wr && sfr_addr == `TMC_ADDR_TMC)   tmc_reg   <= sfr_wdata;
      if (sfr_wr && sfr_addr == `TMC_ADDR_T2CTL) t2ctl_reg <= sfr_wdata;
      if (sfr_wr && sfr_addr == `TMC_ADDR_CRLO)  cr_lo_reg <= sfr_wdata;
      if (sfr_wr && sfr_addr == `TMC_ADDR_CRHI)  cr_hi_reg <= sfr_wdata;
    end
  end

  assign timer_zero_overflow_flag = tcs_reg[`TMC_BIT_OVF0];
  assign timer_one_overflow_flag  = tcs_reg[`TMC_BIT_OVF1];
  assign ext_irq_zero_flag        = tcs_reg[`TMC_BIT_XFLAG0];
  assign ext_irq_one_flag         = tcs_reg[`TMC_BIT_XFLAG1];

  // Reload trigger: low frequency clock halved here, its falling edge reloads
  always @(posedge ref_clk) begin
    if (srst) begin
      lf_div_reg      <= 1'b0;
      lf_div_prev_reg <= 1'b0;
      two_fall_reg    <= 1'b0;
    end else begin
      if (sync2_reg[5] && !prev_reg[5]) lf_div_reg <= ~lf_div_reg;
      lf_div_prev_reg <= lf_div_reg;
      two_fall_reg    <= fall[4];
    end
  end

  assign trig_fall = lf_div_prev_reg & ~lf_div_reg;
  assign reload_sel = t2ctl_reg[`TMC_RLD_HI:`TMC_RLD_LO];
  assign input_sel  = t2ctl_reg[`TMC_SEL_HI:`TMC_SEL_LO];
  // Divide by 24 takes every other divide-by-12 tick
  assign two_tick = tick12 & (~t2ctl_reg[`TMC_BIT_PRESC] | half_reg);

  // Input select picks the timer two count source
  assign two_step = (input_sel == `TMC_SEL_CLK)   ? two_tick :
                    (input_sel == `TMC_SEL_EDGE)  ? two_fall_reg :
                    (input_sel == `TMC_SEL_GATED) ? (two_tick & sync2_reg[4]) :
                    1'b0;
  assign two_ovf = two_step && (two_cnt_reg == 16'hffff);

  // Timer two counter with reload; a byte write takes priority
  always @(posedge ref_clk) begin
    if (srst) begin
      two_cnt_reg <= {`TMC_CNT_RESET, `TMC_CNT_RESET};
    end else if (sfr_wr && sfr_addr == `TMC_ADDR_T2LO) begin
      two_cnt_reg[7:0] <= sfr_wdata;
    end else if (sfr_wr && sfr_addr == `TMC_ADDR_T2HI) begin
      two_cnt_reg[15:8] <= sfr_wdata;
    end else if ((reload_sel == `TMC_RLD_OVF && two_ovf) || (reload_sel == `TMC_RLD_EDGE && trig_fall)) begin
      two_cnt_reg <= {cr_hi_reg, cr_lo_reg};
    end else if (two_step) begin
      two_cnt_reg <= two_cnt_reg + 16'd1;
    end
  end

  // Read data is registered; unmapped addresses read as zero
  always @(posedge ref_clk) begin
    if (srst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        `TMC_ADDR_TCS:   sfr_rdata <= tcs_reg;
        `TMC_ADDR_TMC:   sfr_rdata <= tmc_reg;
        `TMC_ADDR_T0LO:  sfr_rdata <= lo_reg[0];
        `TMC_ADDR_T0HI:  sfr_rdata <= hi_reg[0];
        `TMC_ADDR_T1LO:  sfr_rdata <= lo_reg[1];
        `TMC_ADDR_T1HI:  sfr_rdata <= hi_reg[1];
        `TMC_ADDR_T2CTL: sfr_rdata <= t2ctl_reg;
        `TMC_ADDR_CRLO:  sfr_rdata <= cr_lo_reg;
        `TMC_ADDR_CRHI:  sfr_rdata <= cr_hi_reg;
        `TMC_ADDR_T2LO:  sfr_rdata <= two_cnt_reg[7:0];
        `TMC_ADDR_T2HI:  sfr_rdata <= two_cnt_reg[15:8];
        default:         sfr_rdata <= 8'h00;
      endcase
    end
  end

endmodule

/* File: verification/tmc_core_model.sv */
// Core side of the register bus: register cycles and service-entry pulses
module tmc_core_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] sfr_rdata,
  output logic      [7:0] sfr_addr,
  output logic      [7:0] sfr_wdata,
  output logic            sfr_wr,
  output logic            sfr_rd,
  output logic      [3:0] ack
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {sfr_addr, sfr_wdata, sfr_wr, sfr_rd, ack} = '0;
  // Strobes last one cycle; address and data hold until the strobe drops
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk) {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
    @(negedge ref_clk) sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk) {sfr_addr, sfr_rd} = {a, 1'b1};
    @(negedge ref_clk) sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask
  // Service entry of one source: 0/1 timers, 2/3 external lines
  task automatic svc(input int i);
    @(negedge ref_clk) ack[i] = 1'b1;
    @(negedge ref_clk) ack[i] = 1'b0;
  endtask
endmodule

/* File: verification/tmc_timers_sva.sv */
// Port assertions for the timer/counter block
module tmc_timers_chk (
  input wire logic       ref_clk,
  input wire logic       srst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic       ext_irq_zero_n,
  input wire logic       ext_irq_one_n,
  input wire logic       ack_ext_irq_zero,
  input wire logic       ack_ext_irq_one,
  input wire logic       ext_irq_zero_flag,
  input wire logic       ext_irq_one_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire tcs_wr = sfr_wr && sfr_addr == 8'h88;
  // Mode write, a quiet cycle, then a read of the same place
  sequence s_mode_wr_rd;
    sfr_wr && sfr_addr == 8'h89 ##1 !sfr_wr ##1 sfr_rd && sfr_addr == 8'h89;
  endsequence
  // Pin high so long that no edge is left in the synchroniser
  sequence s_svc0;
    ext_irq_zero_n [*8] ##0 ack_ext_irq_zero && !tcs_wr;
  endsequence
  sequence s_svc1;
    ext_irq_one_n [*8] ##0 ack_ext_irq_one && !tcs_wr;
  endsequence
  a_reset_all_low: assert property (
    $past(srst) |-> !ext_irq_zero_flag && !ext_irq_one_flag && sfr_rdata == 8'h00)
    else $error("state not cleared by reset");
  a_gap_reads_zero: assert property (
    sfr_rd && !(sfr_addr inside {[8'h88:8'h8d], 8'hc8, [8'hca:8'hcd]}) |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (
    !sfr_rd |=> $stable(sfr_rdata)) else $error("read data moved without a read");
  a_mode_readback: assert property (
    s_mode_wr_rd |=> sfr_rdata == $past(sfr_wdata, 3)) else $error("mode readback wrong");
  a_line0_has_cause: assert property (
    $rose(ext_irq_zero_flag) |-> $past(tcs_wr && sfr_wdata[1]) || !$past(ext_irq_zero_n, 2) ||
      !$past(ext_irq_zero_n, 3) || !$past(ext_irq_zero_n, 4)) else $error("line zero flag without cause");
  a_line1_has_cause: assert property (
    $rose(ext_irq_one_flag) |-> $past(tcs_wr && sfr_wdata[3]) || !$past(ext_irq_one_n, 2) ||
      !$past(ext_irq_one_n, 3) || !$past(ext_irq_one_n, 4)) else $error("line one flag without cause");
  a_svc_clears_line0: assert property (
    s_svc0 |=> !ext_irq_zero_flag) else $error("line zero flag kept after service");
  a_svc_clears_line1: assert property (
    s_svc1 |=> !ext_irq_one_flag) else $error("line one flag kept after service");
endmodule
bind tmc_timers tmc_timers_chk u_chk (.ref_clk, .srst, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata,
  .ext_irq_zero_n, .ext_irq_one_n, .ack_ext_irq_zero, .ack_ext_irq_one, .ext_irq_zero_flag, .ext_irq_one_flag);

/* File: verification/tmc_timers_tb.sv */
// Self-checking bench for the timer/counter block
module tmc_timers_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk = 1'b0;
  logic       srst    = 1'b1;
  logic [1:0] cnt_in  = 2'b11;
  logic       ext2_in = 1'b1;
  logic [1:0] irq_n   = 2'b11;
  logic       lf_clk  = 1'b0;
  wire  [7:0] addr, wdata, rdata;
  wire        wr, rd;
  wire  [3:0] ack;
  wire  [1:0] tf, ie;
  logic [7:0] d;
  int         miscompares = 0;
  int         n_checks    = 0;
  int         c;
  always #2.5 ref_clk = ~ref_clk;
  // Slow clock edges fall on core clock falling edges
  always #100 lf_clk = ~lf_clk;
  tmc_core_model u_core (.ref_clk(ref_clk), .sfr_rdata(rdata), .sfr_addr(addr), .sfr_wdata(wdata),
    .sfr_wr(wr), .sfr_rd(rd), .ack(ack));
  tmc_timers u_dut (.ref_clk(ref_clk), .srst(srst), .sfr_addr(addr), .sfr_wdata(wdata), .sfr_wr(wr),
    .sfr_rd(rd), .sfr_rdata(rdata), .timer_zero_count_input(cnt_in[0]), .timer_one_count_input(cnt_in[1]),
    .timer_two_external_input(ext2_in), .ext_irq_zero_n(irq_n[0]), .ext_irq_one_n(irq_n[1]),
    .low_frequency_clock(lf_clk), .ack_timer_zero(ack[0]), .ack_timer_one(ack[1]),
    .ack_ext_irq_zero(ack[2]), .ack_ext_irq_one(ack[3]), .timer_zero_overflow_flag(tf[0]),
    .timer_one_overflow_flag(tf[1]), .ext_irq_zero_flag(ie[0]), .ext_irq_one_flag(ie[1]));
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Window compare; counts near a tick may land either side of it
  task automatic chk_rng(string nm, logic [7:0] lo, logic [7:0] hi, logic [7:0] g);
    n_checks++;
    if ($isunknown(g) || g < lo || g > hi) begin
      miscompares++;
      $display("FAIL %s expected %h..%h seen %h", nm, lo, hi, g);
    end
  endtask
  task automatic rchk(string nm, logic [7:0] a, logic [7:0] e);
    u_core.rd(a, d);
    chk_rng(nm, e, e, d);
  endtask
  task automatic idle(int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Counts falling edges until an overflow flag shows; a hang ends the run
  task automatic wait_tf(int i);
    c = 0;
    while (tf[i] !== 1'b1) begin
      @(negedge ref_clk);
      c++;
      if (c > 250) begin
        miscompares++;
        test_done;
      end
    end
  endtask
  // Both count pins and the event pin fall together, two cycles low, two high
  task automatic pulses(int n);
    repeat (n) begin
      idle(2);
      {cnt_in, ext2_in} = 3'b000;
      idle(2);
      {cnt_in, ext2_in} = 3'b111;
    end
    idle(6);
  endtask
  task automatic t_regs;
    rchk("tcs", 8'h88, 8'h00);
    rchk("t2ctl", 8'hc8, 8'h00);
    u_core.wr(8'h89, 8'ha5);
    rchk("mode", 8'h89, 8'ha5);
    rchk("gap", 8'h8e, 8'h00);
  endtask
  // Auto-reload: four ticks of twelve cycles between overflows
  task automatic t_reload(int i);
    logic [7:0] lo;
    u_core.wr(8'h89, 8'h22);
    u_core.wr(8'h8c + 8'(i), 8'hfc);
    u_core.wr(8'h8a + 8'(i), 8'hfc);
    u_core.wr(8'h88, 8'h10 << (2 * i));
    wait_tf(i);
    u_core.svc(i);
    chk_rng("tf", 8'h00, 8'h00, {7'h00, tf[i]});
    wait_tf(i);
    chk_rng("period", 8'd44, 8'd48, 8'(c));
    u_core.wr(8'h88, 8'h00);
    u_core.rd(8'h8a + 8'(i), lo);
    idle(60);
    rchk("stop", 8'h8a + 8'(i), lo);
    rchk("reload", 8'h8c + 8'(i), 8'hfc);
  endtask
  // 13-bit and 16-bit wrap from all ones on the first tick
  task automatic t_wide;
    for (int m = 0; m < 2; m++) begin
      u_core.wr(8'h89, 8'(m));
      u_core.wr(8'h8c, 8'hff);
      u_core.wr(8'h8a, 8'hff);
      u_core.wr(8'h88, 8'h10);
      wait_tf(0);
      chk_rng("first", 8'd0, 8'd13, 8'(c));
      u_core.wr(8'h88, 8'h00);
      rchk("low", 8'h8a, m ? 8'h00 : 8'he0);
      rchk("high", 8'h8c, 8'h00);
    end
  endtask
  // Timer zero counts pin edges only while its gate line is high; ungated timer one counts all of them
  task automatic t_count;
    u_core.wr(8'h89, 8'h5d);
    u_core.wr(8'h8b, 8'h00);
    irq_n[0] = 1'b0;
    u_core.wr(8'h88, 8'h50);
    pulses(3);
    rchk("gated", 8'h8a, 8'h00);
    irq_n[0] = 1'b1;
    pulses(3);
    rchk("events", 8'h8a, 8'h03);
    rchk("events one", 8'h8b, 8'h06);
    u_core.wr(8'h88, 8'h00);
  endtask
  // Split timer zero: low byte raises flag zero, high byte flag one; timer one wraps silently
  task automatic t_split;
    logic [7:0] lo;
    u_core.wr(8'h89, 8'h13);
    u_core.wr(8'h8d, 8'hff);
    u_core.wr(8'h8b, 8'hff);
    u_core.wr(8'h8c, 8'hfe);
    u_core.wr(8'h8a, 8'hfd);
    u_core.wr(8'h88, 8'h50);
    wait_tf(1);
    chk_rng("split hi", 8'd13, 8'd24, 8'(c));
    chk_rng("split flag0", 8'h00, 8'h00, {7'h00, tf[0]});
    wait_tf(0);
    chk_rng("split lo", 8'd12, 8'd12, 8'(c));
    u_core.wr(8'h88, 8'h00);
    rchk("split low", 8'h8a, 8'h00);
    rchk("split high", 8'h8c, 8'h01);
    u_core.wr(8'h89, 8'h33);
    u_core.wr(8'h88, 8'h40);
    u_core.rd(8'h8b, lo);
    idle(30);
    rchk("one hold", 8'h8b, lo);
    u_core.wr(8'h88, 8'h00);
  endtask
  // Level type keeps the flag through service while the pin is low
  task automatic t_irq;
    for (int k = 0; k < 4; k++) begin
      u_core.wr(8'h88, 8'(k % 2) << (k & 2));
      irq_n[k / 2] = 1'b0;
      idle(8);
      chk_rng("set", 8'h01, 8'h01, {7'h00, ie[k / 2]});
      u_core.svc(2 + k / 2);
      chk_rng("held", 8'(1 - k % 2), 8'(1 - k % 2), {7'h00, ie[k / 2]});
      irq_n[k / 2] = 1'b1;
      idle(10);
      u_core.svc(2 + k / 2);
      chk_rng("clear", 8'h00, 8'h00, {7'h00, ie[k / 2]});
    end
  endtask
  task automatic t_two;
    u_core.wr(8'hca, 8'h34);
    u_core.wr(8'hcb, 8'h12);
    for (int p = 0; p < 3; p++) begin
      u_core.wr(8'hcc, 8'(p / 2) * 8'hff);
      u_core.wr(8'hcd, 8'(p / 2) * 8'hff);
      u_core.wr(8'hc8, (p == 2) ? 8'h11 : (8'(p) << 7 | 8'h01));
      idle(p == 2 ? 14 : 240);
      u_core.wr(8'hc8, 8'h00);
      u_core.rd(8'hcc, d);
      chk_rng("two", p == 2 ? 8'h34 : 8'd19 - 8'(10 * p), p == 2 ? 8'h35 : 8'd21 - 8'(10 * p), d);
    end
    u_core.wr(8'hcd, 8'h00);
    u_core.wr(8'hc8, 8'h19);
    idle(100);
    u_core.wr(8'hc8, 8'h00);
    rchk("trig", 8'hcd, 8'h12);
    u_core.wr(8'hcc, 8'h00);
    u_core.wr(8'hc8, 8'h02);
    pulses(5);
    rchk("event", 8'hcc, 8'h05);
    // Gated clock: nothing while the pin is low, five ticks in sixty cycles high
    u_core.wr(8'hcc, 8'h00);
    ext2_in = 1'b0;
    u_core.wr(8'hc8, 8'h03);
    idle(60);
    rchk("gate low", 8'hcc, 8'h00);
    ext2_in = 1'b1;
    idle(60);
    u_core.wr(8'hc8, 8'h00);
    rchk("gate high", 8'hcc, 8'h05);
  endtask
  initial begin
    idle(2);
    srst = 1'b0;
    t_regs;
    t_reload(0);
    t_reload(1);
    t_wide;
    t_count;
    t_split;
    t_irq;
    t_two;
    test_done;
  end
endmodule
